// ---- core/err_counter.sv ----
// Purpose: One saturating clear-on-read event counter with lower-byte snapshot at upper read
// Assumes: Reads of upper and lower byte are single-cycle strobes
// Notes: An event in a full clearing cycle is kept as a count of one; at an upper read with WIDTH over 8 it adds to the kept lower byte
`include "performance_monitor_cfg.svh"
module err_counter #(
   parameter int WIDTH = 16
) (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Async reset
   input wire logic event_in, // One-cycle event pulse
   input wire logic rd_high, // Upper byte read strobe
   input wire logic rd_low, // Lower byte read strobe
   output logic [WIDTH-1:0] count, // Live count
   output logic [7:0] low_snap // Lower byte held at upper read
);
   logic [WIDTH-1:0] cnt_ff;
   logic [7:0] snap_ff;
   logic [WIDTH-1:0] nxt_cnt;
   logic [WIDTH-1:0] base;

   // Clear-on-read base; saturating so a long gap never wraps to a small number
   always_comb
   begin
      base = (rd_low || (WIDTH <= 8 && rd_high)) ? '0 : cnt_ff;
      if (WIDTH > 8 && rd_high)
         base = cnt_ff & WIDTH'(16'h00ff); // upper cleared, lower kept
      nxt_cnt = base;
      if (event_in && base != '1)
         nxt_cnt = base + 1'b1; // event in clearing cycle survives
   end

   // Count register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end

   // Lower byte frozen at upper read so both halves come from one instant
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         snap_ff <= 8'h00;
      else if (rd_high)
         snap_ff <= cnt_ff[7:0];
   end

   assign count = cnt_ff;
   assign low_snap = snap_ff;

   cnt_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_low && !event_in |=> cnt_ff == '0) else $error("count not cleared on read");
   cnt_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_low && event_in |=> cnt_ff == 1) else $error("event lost on clear");
endmodule : err_counter

// ---- core/performance_monitor_cfg.svh ----
// Purpose: Offsets, field positions, reset values for the receive error counters
// Assumes: Byte-wide register port, word index equals printed low offset
// Notes: The channel digit of the address is decoded outside this block
`ifndef PERFORMANCE_MONITOR_CFG_SVH
`define PERFORMANCE_MONITOR_CFG_SVH
`define FAE_LOW_OFFSET 12'h903
`define SEF_OFFSET 12'h904
`define CRC_HIGH_OFFSET 12'h905
`define CRC_LOW_OFFSET 12'h906
`define IRQ_STATUS_OFFSET 12'h910
`define IRQ_MASK_OFFSET 12'h911
`define CNT_RESET 16'h0000
`define MASK_RESET 8'h00
`define EV_FAE_BIT 0
`define EV_SEF_BIT 1
`define EV_CRC_BIT 2
`define EV_WIDTH 3
`endif

// ---- core/performance_monitor_pkg.sv ----
// Purpose: Types shared by the counter bank
// Assumes: Nothing
// Notes: Constants live in performance_monitor_cfg.svh
package performance_monitor_pkg;
   typedef logic [11:0] addr_t;
   typedef logic [7:0] byte_t;
endpackage : performance_monitor_pkg

// ---- core/rx_performance_monitor_counters.sv ----
// Contract
// - Framing alignment errors accumulate in a 16-bit counter whose low byte has its own register.
// - Each counter shows events since its last read and reading resets it.
// - A 16-bit counter is fully cleared by an upper read followed by a lower read.
// - Severely errored frames are counted in an 8-bit clear-on-read counter.
// - A severely errored frame is two consecutive errored alignment signals with no loss of frame.
// - CRC-4 sync bit errors accumulate in a 16-bit counter readable as two adjacent bytes.
//
// Purpose: Receive performance monitor error counter bank with interrupt
// Assumes: Framer pulses are synchronous to ref_clk, one cycle per event
// Notes: Read data stands only in the cycle after the read strobe
`include "performance_monitor_cfg.svh"
module rx_performance_monitor_counters #(
   parameter int CNT_WIDTH = 16,
   parameter int SEF_WIDTH = 8
) (
   input wire logic ref_clk, // 125 MHz clock
   input wire logic rst, // Async reset, active high
   input wire performance_monitor_pkg::addr_t addr, // Register address
   input wire performance_monitor_pkg::byte_t wr_data, // Write data
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   output performance_monitor_pkg::byte_t rd_data, // Read data, one cycle later
   input wire logic fas_err, // Errored frame alignment signal flag, valid with fas_check
   input wire logic fas_check, // Alignment signal checked this cycle
   input wire logic loss_of_frame, // Loss of frame level from framer
   input wire logic crc_sync_err, // CRC-4 sync bit error pulse
   output logic irq // Level interrupt
);
   logic rd_fae_low, rd_sef, rd_crc_high, rd_crc_low;
   logic [CNT_WIDTH-1:0] fae_cnt, crc_cnt;
   logic [SEF_WIDTH-1:0] sef_cnt;
   logic [7:0] fae_snap, crc_snap, sef_snap_unused;
   logic prev_fas_err_ff;
   logic sef_event;
   performance_monitor_pkg::byte_t rd_data_ff;
   performance_monitor_pkg::byte_t nxt_rd_data;
   logic [`EV_WIDTH-1:0] status_ff, mask_ff, events;
   logic irq_ff;

   // Read strobes per counter
   assign rd_fae_low = rd_en && addr == `FAE_LOW_OFFSET;
   assign rd_sef = rd_en && addr == `SEF_OFFSET;
   assign rd_crc_high = rd_en && addr == `CRC_HIGH_OFFSET;
   assign rd_crc_low = rd_en && addr == `CRC_LOW_OFFSET;

   // Two errored checks in a row; a loss of frame swallows the pair
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         prev_fas_err_ff <= 1'b0;
      else if (loss_of_frame)
         prev_fas_err_ff <= 1'b0;
      else if (fas_check)
         prev_fas_err_ff <= fas_err && !sef_event; // no overlap of pairs
   end
   assign sef_event = fas_check && fas_err && prev_fas_err_ff && !loss_of_frame;

   // Framing alignment counter; upper byte not mapped, so no upper read reaches it
   err_counter #(.WIDTH(CNT_WIDTH)) u_fae (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(fas_check && fas_err),
      .rd_high(1'b0),
      .rd_low(rd_fae_low),
      .count(fae_cnt),
      .low_snap(fae_snap)
   );

   err_counter #(.WIDTH(SEF_WIDTH)) u_sef (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(sef_event),
      .rd_high(rd_sef),
      .rd_low(1'b0),
      .count(sef_cnt),
      .low_snap(sef_snap_unused)
   );

   err_counter #(.WIDTH(CNT_WIDTH)) u_crc (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_in(crc_sync_err),
      .rd_high(rd_crc_high),
      .rd_low(rd_crc_low),
      .count(crc_cnt),
      .low_snap(crc_snap)
   );

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      nxt_rd_data = 8'h00;
      if (!rd_en)
         nxt_rd_data = 8'h00;
      else if (addr == `FAE_LOW_OFFSET)
         nxt_rd_data = fae_cnt[7:0];
      else if (addr == `SEF_OFFSET)
         nxt_rd_data = 8'(sef_cnt);
      else if (addr == `CRC_HIGH_OFFSET)
         nxt_rd_data = crc_cnt[15:8];
      else if (addr == `CRC_LOW_OFFSET)
         nxt_rd_data = crc_snap; // valid only after upper read
      else if (addr == `IRQ_STATUS_OFFSET)
         nxt_rd_data = 8'(status_ff);
      else if (addr == `IRQ_MASK_OFFSET)
         nxt_rd_data = 8'(mask_ff);
   end

   // Read data register, zero outside the answer cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rd_data_ff <= 8'h00;
      else
         rd_data_ff <= nxt_rd_data;
   end
   assign rd_data = rd_data_ff;

   // Sticky status; set beats write-one-to-clear
   assign events = {crc_sync_err, sef_event, fas_check && fas_err};
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         status_ff <= '0;
      else if (wr_en && addr == `IRQ_STATUS_OFFSET)
         status_ff <= (status_ff & ~wr_data[`EV_WIDTH-1:0]) | events;
      else
         status_ff <= status_ff | events;
   end

   // Mask register, one enables the source
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         mask_ff <= `EV_WIDTH'(`MASK_RESET);
      else if (wr_en && addr == `IRQ_MASK_OFFSET)
         mask_ff <= wr_data[`EV_WIDTH-1:0];
   end

   // Registered interrupt, lags status by one cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(status_ff & mask_ff);
   end
   assign irq = irq_ff;

   // Checks
   sef_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
      sef_event |-> fas_err && !loss_of_frame && prev_fas_err_ff) else $error("bad sef event");
   sef_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_sef && !sef_event |=> sef_cnt == 0) else $error("sef not cleared");
   fae_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_fae_low |=> rd_data == $past(fae_cnt[7:0])) else $error("fae low wrong");
   crc_high_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_crc_high && !(crc_sync_err && crc_cnt[7:0] == 8'hff) |=>
      rd_data == $past(crc_cnt[15:8]) && crc_cnt[15:8] == 8'h00) else $error("crc high");
   crc_snap_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_crc_high ##1 rd_crc_low |=> rd_data == $past(crc_snap)) else $error("crc snap");
   crc_seq_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_crc_high ##1 (rd_crc_low && !crc_sync_err) |=> crc_cnt == 0) else $error("crc not cleared");
   crc_count_a: assert property (@(posedge ref_clk) disable iff (rst)
      crc_sync_err && !rd_en && crc_cnt != 16'hffff |=> crc_cnt == $past(crc_cnt) + 16'h0001)
      else $error("crc miss");
   rd_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      !rd_en |=> rd_data == 8'h00) else $error("read data outside answer");
   irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
      |(status_ff & mask_ff) |=> irq) else $error("irq missing");

   // Counting checks; saturation excluded since a full counter holds its value
   sef_count_a: assert property (@(posedge ref_clk) disable iff (rst)
      sef_event && !rd_sef && sef_cnt != '1 |=> sef_cnt == $past(sef_cnt) + 1'b1)
      else $error("sef miss");
   fae_count_a: assert property (@(posedge ref_clk) disable iff (rst)
      fas_check && fas_err && !rd_fae_low && fae_cnt != '1 |=> fae_cnt == $past(fae_cnt) + 1'b1)
      else $error("fae miss");

   // Clear check and read-value check for the single-byte mapped counters
   fae_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_fae_low && !(fas_check && fas_err) |=> fae_cnt == 0) else $error("fae not cleared");
   sef_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_sef |=> rd_data == $past(8'(sef_cnt))) else $error("sef read wrong");

   // Lower byte answers from the snapshot, and an event on the clear is kept
   crc_low_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_crc_low |=> rd_data == $past(crc_snap)) else $error("crc low wrong");
   crc_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_crc_low && crc_sync_err |=> crc_cnt == 16'h0001) else $error("crc event lost");

   // Interrupt side: status sets on events, mask loads, irq drops with no enabled source
   status_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      events != '0 |=> (status_ff & $past(events)) == $past(events)) else $error("status not set");
   mask_load_a: assert property (@(posedge ref_clk) disable iff (rst)
      wr_en && addr == `IRQ_MASK_OFFSET |=> mask_ff == $past(wr_data[`EV_WIDTH-1:0]))
      else $error("mask not loaded");
   irq_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
      !(|(status_ff & mask_ff)) |=> !irq) else $error("irq stuck");
   crc_keep_c: cover property (@(posedge ref_clk) rd_crc_low && crc_sync_err);
   sef_lof_c: cover property (@(posedge ref_clk) fas_check && fas_err && prev_fas_err_ff && loss_of_frame);
   sef_cov_c: cover property (@(posedge ref_clk) sef_event);
   crc_seq_c: cover property (@(posedge ref_clk) rd_crc_high ##1 rd_crc_low);
   irq_cov_c: cover property (@(posedge ref_clk) $rose(irq));
endmodule : rx_performance_monitor_counters

// ---- dv/framer_model.sv ----
// Purpose: Receive framer model giving error pulses
// Assumes: Bench requests are one cycle each
// Notes: Flag wanders outside checks
module framer_model (
   input wire logic ref_clk, // Clock
   input wire logic chk_req, // Check a signal
   input wire logic err_req, // Check errored
   input wire logic crc_req, // Sync bit error
   input wire logic lof_req, // Loss of frame
   output logic fas_check, // Check pulse
   output logic fas_err, // Errored flag
   output logic crc_sync_err, // Error pulse
   output logic loss_of_frame // Loss level
);
   timeunit 1ns;
   timeprecision 1ps;
   initial fas_err = 1'b0;
   // Flag toggles off checks so a stale value is never trusted
   always @(posedge ref_clk)
   begin
      fas_check <= chk_req;
      fas_err <= chk_req ? err_req : ~fas_err;
      crc_sync_err <= crc_req;
      loss_of_frame <= lof_req;
   end
endmodule : framer_model

// ---- dv/rx_performance_monitor_counters_tb.sv ----
// Purpose: Self-checking bench for the error counter bank
// Assumes: Framer model drives the event inputs
// Notes: Counts kept small for a short run
`include "performance_monitor_cfg.svh"
module rx_performance_monitor_counters_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, irq;
   logic chk_req = 1'b0, err_req = 1'b0, crc_req = 1'b0, lof_req = 1'b0;
   logic fas_check, fas_err, crc_sync_err, loss_of_frame;
   performance_monitor_pkg::addr_t addr = 12'h000;
   performance_monitor_pkg::byte_t wr_data = 8'h00, rd_data, hi, lo;
   performance_monitor_pkg::addr_t ra[7] = '{12'h903, 12'h904, 12'h905, 12'h906, 12'h910, 12'h911, 12'h123};
   int bad_count = 0, cmp_count = 0, cyc = 0, k, m;
   rx_performance_monitor_counters i_rx_performance_monitor_counters (.ref_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .fas_err, .fas_check, .loss_of_frame, .crc_sync_err, .irq);
   framer_model i_framer_model (.ref_clk, .chk_req, .err_req, .crc_req, .lof_req,
      .fas_check, .fas_err, .crc_sync_err, .loss_of_frame);
   initial forever #4 ref_clk = ~ref_clk;
   // Pairs never overlap; loss of frame voids them
   function automatic logic [15:0] sef_exp(input int ne, input logic lof);
      return lof ? 16'h0000 : 16'(ne / 2);
   endfunction : sef_exp
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("counts: %0d compared, %0d bad", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic wr(input performance_monitor_pkg::addr_t a, input performance_monitor_pkg::byte_t d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input performance_monitor_pkg::addr_t a, output performance_monitor_pkg::byte_t d);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd
   // Upper then lower read back to back; an optional sync error lands on the clearing read
   task automatic rd16(input logic pulse, output performance_monitor_pkg::byte_t h, output performance_monitor_pkg::byte_t l);
      @(posedge ref_clk);
      addr <= `CRC_HIGH_OFFSET;
      rd_en <= 1'b1;
      crc_req <= pulse;
      @(posedge ref_clk);
      addr <= `CRC_LOW_OFFSET;
      crc_req <= 1'b0;
      #1 h = rd_data;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 l = rd_data;
   endtask : rd16
   // Errored checks in a row, one clean check, and sync errors alongside
   task automatic ev(input int ne, input int nc, input logic lof);
      for (int i = 0; i <= ((ne > nc) ? ne : nc); i++)
      begin
         @(posedge ref_clk);
         chk_req <= (i <= ne);
         err_req <= (i < ne);
         crc_req <= (i < nc);
         lof_req <= lof;
      end
      @(posedge ref_clk);
      chk_req <= 1'b0;
      crc_req <= 1'b0;
      lof_req <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : ev
   // Hang guard
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         close_out();
      end
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'hec6c));
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      wr(12'h903, 8'h5a);
      wr(12'h123, 8'hff);
      foreach (ra[i])
      begin
         rd(ra[i], lo);
         chk(lo, 16'h0000);
      end
      $display("test reset done");
      for (int t = 0; t < 6; t++)
      begin
         k = (t == 1) ? 0 : $urandom_range(20);
         m = (t == 0) ? 300 : (t == 1) ? 0 : $urandom_range(300);
         ev(k, m, 1'b0);
         rd16(t[0], hi, lo); // Upper first
         chk({hi, lo}, 16'(m));
         rd16(1'b0, hi, lo);
         chk({hi, lo}, 16'(t % 2));
         rd(`FAE_LOW_OFFSET, lo);
         chk(lo, 16'(k & 8'hff));
         rd(`SEF_OFFSET, lo);
         chk(lo, sef_exp(k, 1'b0));
         rd(`SEF_OFFSET, lo);
         chk(lo, 16'h0000);
         $display("test counts %0d done", t);
      end
      ev(6, 0, 1'b1);
      rd(`SEF_OFFSET, lo);
      chk(lo, sef_exp(6, 1'b1));
      rd(`FAE_LOW_OFFSET, lo);
      chk(lo, 16'h0006);
      $display("test loss of frame done");
      ev(4, 1, 1'b0);
      #1 chk(irq, 1'b0);
      wr(`IRQ_MASK_OFFSET, 8'h07);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq, 1'b1);
      rd(`IRQ_STATUS_OFFSET, lo);
      chk(lo, 16'h0007);
      wr(`IRQ_STATUS_OFFSET, 8'h07);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq, 1'b0);
      $display("test interrupt done");
      close_out();
   end
endmodule : rx_performance_monitor_counters_tb
